// file: verilog/rtc_control_alarm_dst.sv
// Control, weekday alarm gate and forward-jump logic of the clock block
// Summary of operation
// - Alarm logic works only while alarm enabled
// - Writing self-reset one starts internal reset
// - Internal reset clears all but control
// - Self-reset bit clears itself one cycle later
// - Block halted while block-on bit zero
// - Valid weekday must match day-of-week
// - Top bits both one: don't-care, reads FF
// - Matching hour adds one extra hour
// - Week field: codes 1-4, 5 last
// - Hour in 30:24, meridiem in 31
// - Weekday in 10:8, month in 7:0
// - Forward register writable by word or byte
// - Hour and month take format at write
// - Stored fields ignore later format change
// - Alarms in skipped hour never fire; here alarm_evt is not gated by the forward jump
// - Alarm flag sticky, cleared by status read
`timescale 1ns/1ps
`include "rtc_ctl_consts.svh"

module rtc_control_alarm_dst
   import rtc_ctl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  wr_be,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic        seasonal_shift_on,
   input  wire logic        binary_vs_bcd_select,
   input  wire logic        hour_mode_12,
   input  wire logic        alarm_irq_en,
   input  wire logic        alarm_hit,
   input  wire logic        hour_tick,
   input  wire logic [7:0]  cur_hours,
   input  wire logic [2:0]  cur_weekday,
   input  wire logic [7:0]  cur_month,
   input  wire logic [7:0]  cur_mday,
   input  wire logic [4:0]  month_days,
   output logic [31:0]      rd_data_q,
   output logic             block_run_q,
   output logic             block_reset_q,
   output logic             extra_hour_q,
   output logic             alarm_flag_q,
   output logic             alarm_irq_q
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   self_reset_state_t sr_state_q;
   logic [3:0]        ctrl_q;
   clk_byte_t         wkalm_q;
   logic [31:0]       fwd_q;
   logic              fwd_bcd_q;
   logic              fwd_12h_q;
   logic              jump_match;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic sel_ctrl = addr == `OFS_BLOCK_CONTROL;
   wire logic sel_wk   = addr == `OFS_WEEKDAY_ALARM;
   wire logic sel_fwd  = addr == `OFS_SUMMER_FWD;
   wire logic sel_stat = addr == `OFS_ALARM_STATUS;
   wire logic wr_ctrl  = wr_en && sel_ctrl && wr_be[0];
   wire logic wr_wk    = wr_en && sel_wk && wr_be[0];
   wire logic wr_fwd   = wr_en && sel_fwd && (wr_be != 4'h0);
   wire logic rd_stat  = rd_en && sel_stat;

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   wire logic blk_rst  = block_reset_q;
   wire logic block_on = ctrl_q[`CTL_BLOCK_ON_BIT];
   wire logic alarm_on = ctrl_q[`CTL_ALARM_ON_BIT];
   wire logic sr_start = wr_ctrl && wr_data[`CTL_SELF_RESET_BIT];
   // Write during the reset cycle must not leave the bit stuck at one
   wire logic sr_go    = sr_start && (sr_state_q == SR_IDLE);
   wire logic [3:0] ctrl_d =
      wr_data[3:0] & ~(4'h1 << `CTL_SELF_RESET_BIT);

   // ----------------------------------------
   // Weekday alarm gate
   // ----------------------------------------
   wire logic wk_dont_care = wkalm_q[7:6] == `DONT_CARE_TOP;
   wire clk_byte_t wkalm_d =
      (wr_data[7:6] == `DONT_CARE_TOP) ? `RST_WEEKDAY_ALARM
                                       : wr_data[7:0];
   wire logic wk_ok = wk_dont_care ||
                      (wkalm_q[2:0] == cur_weekday);
   wire logic alarm_evt = alarm_hit && alarm_on && block_on &&
                          wk_ok && !blk_rst;

   // ----------------------------------------
   // Forward register byte merge
   // ----------------------------------------
   wire logic [31:0] be_mask = {{8{wr_be[3]}}, {8{wr_be[2]}},
                                {8{wr_be[1]}}, {8{wr_be[0]}}};
   wire logic [31:0] fwd_d = ((fwd_q & ~be_mask) | (wr_data & be_mask))
                             & `FWD_USED_MASK;
   wire logic fmt_touch = wr_be[3] || wr_be[0];

   // ----------------------------------------
   // Forward jump decision
   // ----------------------------------------
   jump_ahead_match u_match
   (
      .jump_ahead_month    (fwd_q[`FWD_MONTH_LSB +: 8]),
      .jump_ahead_weekday  (fwd_q[`FWD_WDAY_LSB +: 3]),
      .jump_ahead_week     (fwd_q[`FWD_WEEK_LSB +: 3]),
      .jump_ahead_hour     (fwd_q[`FWD_HOUR_LSB +: 7]),
      .jump_ahead_meridiem (fwd_q[`FWD_MERID_BIT]),
      .fwd_fmt_bcd         (fwd_bcd_q),
      .fwd_fmt_12h         (fwd_12h_q),
      .cur_fmt_bcd         (!binary_vs_bcd_select),
      .cur_hours           (cur_hours),
      .cur_weekday         (cur_weekday),
      .cur_month           (cur_month),
      .cur_mday            (cur_mday),
      .month_days          (month_days),
      .jump_match          (jump_match)
   );

   // Extra hour flagged in the cycle after the rollover tick, skipping the hour
   wire logic jump_d = hour_tick && block_on && seasonal_shift_on &&
                       jump_match && !blk_rst;

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire logic [31:0] rd_mux =
      sel_ctrl ? {28'h0, ctrl_q} :
      sel_wk   ? {24'h0, wkalm_q} :
      sel_fwd  ? fwd_q :
      sel_stat ? {31'h0, alarm_flag_q} : 32'h0;
   wire logic flag_d = alarm_evt || (alarm_flag_q && !rd_stat);

   // ----------------------------------------
   // Self-reset sequencer
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
         sr_state_q <= SR_IDLE;
      else if (ce)
      begin
         case (sr_state_q)
            SR_IDLE: if (sr_start) sr_state_q <= SR_BUSY;
            SR_BUSY: sr_state_q <= SR_IDLE;
            default: sr_state_q <= SR_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         block_reset_q <= 1'b0;
      else if (ce)
         block_reset_q <= sr_go;
   end

   // ----------------------------------------
   // Control register, kept through self reset
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
         ctrl_q <= `RST_CONTROL;
      else if (ce && wr_ctrl)
         ctrl_q <= ctrl_d | ({3'h0, sr_go} << `CTL_SELF_RESET_BIT);
      else if (ce && block_reset_q)
         ctrl_q[`CTL_SELF_RESET_BIT] <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         block_run_q <= 1'b0;
      else if (ce)
         block_run_q <= block_on && !blk_rst;
   end

   // ----------------------------------------
   // Alarm and forward registers
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst || (ce && blk_rst))
         wkalm_q <= `RST_WEEKDAY_ALARM;
      else if (ce && wr_wk)
         wkalm_q <= wkalm_d;
   end

   always_ff @(posedge mclk)
   begin
      if (rst || (ce && blk_rst))
      begin
         fwd_q     <= `RST_SUMMER_FWD;
         fwd_bcd_q <= 1'b0;
         fwd_12h_q <= 1'b0;
      end
      else if (ce && wr_fwd)
      begin
         fwd_q <= fwd_d;
         if (fmt_touch)
         begin
            fwd_bcd_q <= !binary_vs_bcd_select;
            fwd_12h_q <= hour_mode_12;
         end
      end
   end

   // ----------------------------------------
   // Events and read data
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst || (ce && blk_rst))
      begin
         alarm_flag_q <= 1'b0;
         alarm_irq_q  <= 1'b0;
         extra_hour_q <= 1'b0;
      end
      else if (ce)
      begin
         alarm_flag_q <= flag_d;
         alarm_irq_q  <= flag_d && alarm_irq_en;
         extra_hour_q <= jump_d;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         rd_data_q <= 32'h0;
      else if (ce)
         rd_data_q <= rd_en ? rd_mux : 32'h0;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   alarm_gate_a: assert property (
      ce && !alarm_on && !alarm_flag_q |=> !alarm_flag_q)
      else $error("alarm flag set while alarms disabled");

   self_reset_a: assert property (
      ce && sr_start && sr_state_q == SR_IDLE |=> block_reset_q)
      else $error("self reset write did not start reset");

   reset_clear_a: assert property (
      ce && block_reset_q |=> wkalm_q == 8'hFF && fwd_q == 32'h0
                              && !extra_hour_q)
      else $error("self reset left state uncleared");

   self_clear_a: assert property (
      ce && block_reset_q ##1 ce |-> !block_reset_q
         && !ctrl_q[`CTL_SELF_RESET_BIT])
      else $error("self reset bit did not clear");

   halt_run_a: assert property (
      ce && !block_on |=> !block_run_q && !extra_hour_q)
      else $error("block active while halted");

   weekday_gate_a: assert property (
      ce && !wk_dont_care && wkalm_q[2:0] != cur_weekday
         && !alarm_flag_q |=> !alarm_flag_q)
      else $error("alarm passed on wrong weekday");

   dont_care_a: assert property (
      ce && wr_wk && !blk_rst && wr_data[7:6] == 2'h3
      |=> wkalm_q == 8'hFF)
      else $error("weekday don't-care not read as FF");

   jump_fire_a: assert property (
      ce && hour_tick && block_on && seasonal_shift_on && jump_match
         && !blk_rst |=> extra_hour_q)
      else $error("forward jump missed");

   byte_write_a: assert property (
      ce && wr_fwd && !blk_rst && wr_be == 4'h1
      |=> fwd_q[31:8] == $past(fwd_q[31:8]))
      else $error("byte write touched other lanes");

   flag_read_a: assert property (
      ce && rd_stat && !alarm_evt
      |=> !alarm_flag_q && rd_data_q[0] == $past(alarm_flag_q))
      else $error("alarm flag not cleared by read");

   reserved_a: assert property (
      ce && rd_en && sel_fwd |=> (rd_data_q & ~32'hFF07_07FF) == 0)
      else $error("reserved bits read nonzero");

   alarm_c: cover property (ce && alarm_evt ##1 ce && rd_stat);
   jump_c: cover property (ce && jump_d);
   sreset_c: cover property (ce && sr_start ##1 block_reset_q);
   dont_care_c: cover property (ce && wr_wk && wr_data[7:6] == 2'h3);

endmodule : rtc_control_alarm_dst

// file: verilog/rtc_ctl_consts.svh
// Offsets, field positions, reset values for the clock control block
`ifndef RTC_CTL_CONSTS_SVH
`define RTC_CTL_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_BLOCK_CONTROL 8'h10
`define OFS_WEEKDAY_ALARM  8'h14
`define OFS_SUMMER_FWD     8'h18
`define OFS_ALARM_STATUS   8'h20

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTL_BLOCK_ON_BIT   0
`define CTL_SELF_RESET_BIT 1
`define CTL_SPARE_BIT      2
`define CTL_ALARM_ON_BIT   3

// ----------------------------------------
// Forward-jump fields
// ----------------------------------------
`define FWD_MONTH_LSB      0
`define FWD_WDAY_LSB       8
`define FWD_WEEK_LSB       16
`define FWD_HOUR_LSB       24
`define FWD_MERID_BIT      31
`define FWD_USED_MASK      32'hFF07_07FF

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RST_CONTROL        4'h0
`define RST_WEEKDAY_ALARM  8'hFF
`define RST_SUMMER_FWD     32'h0000_0000
`define WEEK_LAST_CODE     3'h5
`define DAYS_PER_WEEK      5'h07
`define DONT_CARE_TOP      2'h3

`endif

// file: verilog/rtc_ctl_pkg.sv
// Types and shared conversion for the clock control block
package rtc_ctl_pkg;

   typedef enum logic [1:0]
   {
      SR_IDLE = 2'b01,
      SR_BUSY = 2'b10
   } self_reset_state_t;

   typedef logic [7:0] clk_byte_t;

   function automatic clk_byte_t to_binary(input clk_byte_t v,
                                           input logic      is_bcd);
      clk_byte_t r;
      r = is_bcd ? clk_byte_t'(v[7:4] * 4'hA + v[3:0]) : v;
      return r;
   endfunction : to_binary

endpackage : rtc_ctl_pkg

// file: verilog/jump_ahead_match.sv
// Forward-jump date and hour comparison with week-of-month tracking
`timescale 1ns/1ps
`include "rtc_ctl_consts.svh"

module jump_ahead_match
   import rtc_ctl_pkg::*;
(
   input  wire logic [7:0] jump_ahead_month,
   input  wire logic [2:0] jump_ahead_weekday,
   input  wire logic [2:0] jump_ahead_week,
   input  wire logic [6:0] jump_ahead_hour,
   input  wire logic       jump_ahead_meridiem,
   input  wire logic       fwd_fmt_bcd,
   input  wire logic       fwd_fmt_12h,
   input  wire logic       cur_fmt_bcd,
   input  wire logic [7:0] cur_hours,
   input  wire logic [2:0] cur_weekday,
   input  wire logic [7:0] cur_month,
   input  wire logic [7:0] cur_mday,
   input  wire logic [4:0] month_days,
   output logic            jump_match
);

   // ----------------------------------------
   // Week of month from day of month
   // ----------------------------------------
   wire clk_byte_t mday_bin = to_binary(cur_mday, cur_fmt_bcd);
   wire logic [2:0] week_num =
      3'((mday_bin - 8'h01) / 8'(`DAYS_PER_WEEK)) + 3'h1;
   wire logic last_week =
      (mday_bin + 8'(`DAYS_PER_WEEK)) > {3'h0, month_days};
   wire logic week_hit = (week_num == jump_ahead_week) ||
      ((jump_ahead_week == `WEEK_LAST_CODE) && last_week);

   // ----------------------------------------
   // Field compares in binary, each side converted from its own format
   // ----------------------------------------
   wire logic month_hit = to_binary(jump_ahead_month, fwd_fmt_bcd) ==
                          to_binary(cur_month, cur_fmt_bcd);
   wire logic wday_hit  = jump_ahead_weekday == cur_weekday;
   wire logic hour_hit  =
      to_binary({1'b0, jump_ahead_hour}, fwd_fmt_bcd) ==
      to_binary({1'b0, cur_hours[6:0]}, cur_fmt_bcd);
   wire logic merid_hit = !fwd_fmt_12h ||
                          (jump_ahead_meridiem == cur_hours[7]);

   assign jump_match = week_hit && month_hit && wday_hit &&
                       hour_hit && merid_hit;

endmodule : jump_ahead_match

// file: verif/testbench.sv
// Register-level testbench for the clock control block
`timescale 1ns/1ps
`include "rtc_ctl_consts.svh"

module testbench;
   logic        mclk;
   logic        rst;
   logic        ce;
   logic [7:0]  addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_be;
   logic        wr_en;
   logic        rd_en;
   logic        seasonal_shift_on;
   logic        binary_vs_bcd_select;
   logic        hour_mode_12;
   logic        alarm_irq_en;
   logic        alarm_hit;
   logic        hour_tick;
   logic [7:0]  cur_hours;
   logic [2:0]  cur_weekday;
   logic [7:0]  cur_month;
   logic [7:0]  cur_mday;
   logic [4:0]  month_days;
   logic [31:0] rd_data_q;
   logic        block_run_q;
   logic        block_reset_q;
   logic        extra_hour_q;
   logic        alarm_flag_q;
   logic        alarm_irq_q;
   int          fails;
   int          tests_run;
   int          n;

   rtc_control_alarm_dst i_dut (.mclk(mclk), .rst(rst), .ce(ce),
      .addr(addr), .wr_data(wr_data), .wr_be(wr_be), .wr_en(wr_en),
      .rd_en(rd_en), .seasonal_shift_on(seasonal_shift_on),
      .binary_vs_bcd_select(binary_vs_bcd_select),
      .hour_mode_12(hour_mode_12), .alarm_irq_en(alarm_irq_en),
      .alarm_hit(alarm_hit), .hour_tick(hour_tick),
      .cur_hours(cur_hours), .cur_weekday(cur_weekday),
      .cur_month(cur_month), .cur_mday(cur_mday),
      .month_days(month_days), .rd_data_q(rd_data_q),
      .block_run_q(block_run_q), .block_reset_q(block_reset_q),
      .extra_hour_q(extra_hour_q), .alarm_flag_q(alarm_flag_q),
      .alarm_irq_q(alarm_irq_q));

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial
   begin
      #(8 * 5000);
      fails++;
      conclude();
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      @(posedge mclk);
      addr    <= a;
      wr_data <= d;
      wr_be   <= be;
      wr_en   <= 1'b1;
      @(posedge mclk);
      wr_en   <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      chk($sformatf("read %h", a), exp, rd_data_q);
   endtask : rd

   // Pulse one input for one cycle, then look at the answer
   task automatic hit(input logic exp_flag, input logic exp_irq);
      @(posedge mclk);
      alarm_hit <= 1'b1;
      @(posedge mclk);
      alarm_hit <= 1'b0;
      #1;
      chk("alarm flag", {31'h0, exp_flag}, {31'h0, alarm_flag_q});
      chk("alarm irq", {31'h0, exp_irq}, {31'h0, alarm_irq_q});
   endtask : hit

   task automatic tick(input logic exp);
      @(posedge mclk);
      hour_tick <= 1'b1;
      @(posedge mclk);
      hour_tick <= 1'b0;
      #1;
      chk("extra hour", {31'h0, exp}, {31'h0, extra_hour_q});
      @(posedge mclk);
      #1;
      chk("extra hour end", 32'h0, {31'h0, extra_hour_q});
   endtask : tick

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      fails = 0;
      tests_run = 0;
      rst = 1'b1;
      ce = 1'b1;
      addr = 8'h00;
      wr_data = 32'h0;
      wr_be = 4'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      seasonal_shift_on = 1'b0;
      binary_vs_bcd_select = 1'b1;
      hour_mode_12 = 1'b0;
      alarm_irq_en = 1'b0;
      alarm_hit = 1'b0;
      hour_tick = 1'b0;
      cur_hours = 8'h00;
      cur_weekday = 3'h3;
      cur_month = 8'h01;
      cur_mday = 8'h01;
      month_days = 5'h1F;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;

      rd(`OFS_BLOCK_CONTROL, 32'h0);
      rd(`OFS_WEEKDAY_ALARM, 32'hFF);
      rd(`OFS_SUMMER_FWD, 32'h0);
      rd(8'h30, 32'h0);
      $display("test reset values done");

      wr(`OFS_BLOCK_CONTROL, 32'hFFFF_FF8D, 4'hF);
      rd(`OFS_BLOCK_CONTROL, 32'h0D);
      chk("block run", 32'h1, {31'h0, block_run_q});
      wr(`OFS_SUMMER_FWD, 32'hFFFF_FFFF, 4'hF);
      rd(`OFS_SUMMER_FWD, 32'hFF07_07FF);
      wr(`OFS_SUMMER_FWD, 32'h0000_0000, 4'h2);
      rd(`OFS_SUMMER_FWD, 32'hFF07_00FF);
      $display("test control and forward access done");

      wr(`OFS_WEEKDAY_ALARM, 32'hC3, 4'h1);
      rd(`OFS_WEEKDAY_ALARM, 32'hFF);
      hit(1'b1, 1'b0);
      rd(8'h20, 32'h1);
      chk("flag after read", 32'h0, {31'h0, alarm_flag_q});
      wr(`OFS_WEEKDAY_ALARM, 32'h03, 4'h1);
      rd(`OFS_WEEKDAY_ALARM, 32'h03);
      cur_weekday <= 3'h4;
      hit(1'b0, 1'b0);
      cur_weekday <= 3'h3;
      alarm_irq_en <= 1'b1;
      hit(1'b1, 1'b1);
      rd(8'h20, 32'h1);
      wr(`OFS_BLOCK_CONTROL, 32'h01, 4'h1);
      hit(1'b0, 1'b0);
      $display("test weekday alarm done");

      // Fields written in BCD: hour 10, last week, weekday 1, month 12
      binary_vs_bcd_select <= 1'b0;
      wr(`OFS_SUMMER_FWD, 32'h1005_0112, 4'hF);
      rd(`OFS_SUMMER_FWD, 32'h1005_0112);
      binary_vs_bcd_select <= 1'b1;
      seasonal_shift_on <= 1'b1;
      cur_hours <= 8'h0A;
      cur_weekday <= 3'h1;
      cur_month <= 8'h0C;
      cur_mday <= 8'h19;
      tick(1'b1);
      tick(1'b1);
      cur_mday <= 8'h14;
      tick(1'b0);
      cur_mday <= 8'h19;
      cur_hours <= 8'h0B;
      tick(1'b0);
      cur_hours <= 8'h0A;
      cur_weekday <= 3'h2;
      tick(1'b0);
      cur_weekday <= 3'h1;
      seasonal_shift_on <= 1'b0;
      tick(1'b0);
      seasonal_shift_on <= 1'b1;
      wr(`OFS_BLOCK_CONTROL, 32'h00, 4'h1);
      tick(1'b0);
      $display("test forward jump done");

      // Binary fields, 12-hour mode: hour 10 PM, last week, weekday 1
      seasonal_shift_on <= 1'b0;
      hour_mode_12 <= 1'b1;
      wr(`OFS_SUMMER_FWD, 32'h8A05_010C, 4'hF);
      wr(`OFS_BLOCK_CONTROL, 32'h01, 4'h1);
      seasonal_shift_on <= 1'b1;
      tick(1'b0);
      cur_hours <= 8'h8A;
      tick(1'b1);
      $display("test twelve hour jump done");

      wr(`OFS_BLOCK_CONTROL, 32'h0B, 4'h1);
      n = 0;
      repeat (4)
      begin
         #1;
         if (block_reset_q === 1'b1)
            n++;
         @(posedge mclk);
      end
      chk("reset pulse count", 32'h1, n);
      rd(`OFS_BLOCK_CONTROL, 32'h09);
      rd(`OFS_WEEKDAY_ALARM, 32'hFF);
      rd(`OFS_SUMMER_FWD, 32'h0);
      chk("block run kept", 32'h1, {31'h0, block_run_q});
      $display("test self reset done");

      ce <= 1'b0;
      hit(1'b0, 1'b0);
      ce <= 1'b1;
      hit(1'b1, 1'b1);
      $display("test clock enable done");

      conclude();
   end
endmodule : testbench
